//--- verilog/alu_flags_pkg.sv
`default_nettype none
package alu_flags_pkg;
    localparam int DATA_W = 8;
    localparam int FLAG_W = 5;
    localparam int ADDR_W = 12;
    localparam int NEG_BIT = 4;
    localparam int OVF_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int NIB_BIT = 1;
    localparam int CARRY_BIT = 0;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
    localparam logic [FLAG_W-1:0] MASK_ALL = 5'h1F;
    localparam logic [FLAG_W-1:0] MASK_ZN = 5'h14;
    localparam logic [FLAG_W-1:0] MASK_Z = 5'h04;
    localparam logic [FLAG_W-1:0] MASK_CZN = 5'h15;
    localparam logic [FLAG_W-1:0] MASK_NONE = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 12'h00C;
    localparam int CTRL_UPD_BIT = 0;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int COUNT_W = 16;
    typedef enum logic [4:0] {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBLIT, OP_INC, OP_DEC,
        OP_AND, OP_OR, OP_XOR, OP_MOVF, OP_CLR, OP_RLC, OP_RRC,
        OP_SWAP, OP_BCLR, OP_BSET, OP_FILE_TO_FILE_MOVE_INSTR, OP_ACCUM_TO_FILE_MOVE_INSTR, OP_PTR
    } aluop_e;
endpackage
`default_nettype wire

//--- verilog/flag_calc_if.sv
`default_nettype none
interface flag_calc_if;
    import alu_flags_pkg::*;
    aluop_e op;
    logic [DATA_W-1:0] opA;
    logic [DATA_W-1:0] opB;
    logic carryIn;
    logic [2:0] bitSel;
    logic [DATA_W-1:0] result;
    logic [FLAG_W-1:0] flagsNew;
    logic [FLAG_W-1:0] affect;
    modport calc (input op, opA, opB, carryIn, bitSel, output result, flagsNew, affect);
    modport user (output op, opA, opB, carryIn, bitSel, input result, flagsNew, affect);
endinterface
`default_nettype wire

//--- verilog/alu_flag_calc.sv
`default_nettype none
module alu_flag_calc
    import alu_flags_pkg::*;
(
    flag_calc_if.calc fc
);
    logic [DATA_W-1:0] addY;
    logic addC;
    logic [DATA_W:0] sum;
    logic [4:0] lowSum;
    logic [DATA_W-1:0] res;
    logic cOut;

    always_comb begin
        addY = '0;
        addC = 1'b0;
        case (fc.op)
            OP_ADD: addY = fc.opA;
            OP_ADDC: begin
                addY = fc.opA;
                addC = fc.carryIn;
            end
            // subtract by adding the complement plus one; carry then means no borrow
            OP_SUB, OP_SUBLIT: begin
                addY = ~fc.opA; // [RQ10]
                addC = 1'b1; // [RQ10]
            end
            OP_INC: addC = 1'b1;
            OP_DEC: addY = 8'hFF;
            default: addY = '0;
        endcase
        sum = {1'b0, fc.opB} + {1'b0, addY} + {8'h00, addC};
        lowSum = {1'b0, fc.opB[3:0]} + {1'b0, addY[3:0]} + {4'h0, addC};
    end

    always_comb begin
        res = sum[DATA_W-1:0];
        cOut = sum[DATA_W]; // [RQ9]
        fc.affect = MASK_ALL;
        case (fc.op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBLIT, OP_INC, OP_DEC: fc.affect = MASK_ALL;
            OP_AND: begin
                res = fc.opA & fc.opB;
                fc.affect = MASK_ZN;
            end
            OP_OR: begin
                res = fc.opA | fc.opB;
                fc.affect = MASK_ZN;
            end
            OP_XOR: begin
                res = fc.opA ^ fc.opB;
                fc.affect = MASK_ZN;
            end
            OP_MOVF: begin
                res = fc.opB;
                fc.affect = MASK_ZN;
            end
            OP_CLR: begin
                res = '0;
                fc.affect = MASK_Z; // [RQ2]
            end
            OP_RLC: begin
                res = {fc.opB[6:0], fc.carryIn};
                cOut = fc.opB[7]; // [RQ11]
                fc.affect = MASK_CZN;
            end
            OP_RRC: begin
                res = {fc.carryIn, fc.opB[7:1]};
                cOut = fc.opB[0]; // [RQ11]
                fc.affect = MASK_CZN;
            end
            OP_SWAP: begin
                res = {fc.opB[3:0], fc.opB[7:4]};
                fc.affect = MASK_NONE;
            end
            OP_BCLR: begin
                res = fc.opB & ~(8'h01 << fc.bitSel);
                fc.affect = MASK_NONE;
            end
            OP_BSET: begin
                res = fc.opB | (8'h01 << fc.bitSel);
                fc.affect = MASK_NONE;
            end
            OP_FILE_TO_FILE_MOVE_INSTR: begin
                res = fc.opB;
                fc.affect = MASK_NONE;
            end
            OP_ACCUM_TO_FILE_MOVE_INSTR: begin
                res = fc.opA;
                fc.affect = MASK_NONE;
            end
            // pointer step: value passes, flags untouched
            OP_PTR: begin
                res = fc.opB;
                fc.affect = MASK_NONE; // [RQ13]
            end
            default: fc.affect = MASK_NONE;
        endcase
        fc.result = res;
        fc.flagsNew[NEG_BIT] = res[DATA_W-1]; // [RQ5]
        fc.flagsNew[OVF_BIT] = (fc.opB[7] == addY[7]) && (res[7] != fc.opB[7]); // [RQ6]
        fc.flagsNew[ZERO_BIT] = (res == '0); // [RQ7]
        fc.flagsNew[NIB_BIT] = lowSum[4]; // [RQ8]
        fc.flagsNew[CARRY_BIT] = cOut; // [RQ9]
    end
endmodule
`default_nettype wire

//--- verilog/alu_condition_flags.sv
// Summary of operation
// [RQ1] an instruction that alters any arithmetic flag with the flag register as destination drops its result and only updates flags
// [RQ2] clearing the flag register sets zero and leaves the other flags as they were
// [RQ3] software should alter the flag register only with bit clear, bit set, nibble swap or move instructions
// [RQ4] negative is bit 4, overflow bit 3, zero bit 2, nibble carry bit 1, carry bit 0, bits 7-5 read zero
// [RQ5] negative follows the most significant bit of the result
// [RQ6] overflow is set when a signed operation wrongly flips the sign bit 7
// [RQ7] zero is set when the result is zero and cleared otherwise
// [RQ8] for add and subtract, nibble carry is the carry out of bit 3
// [RQ9] for add and subtract, carry is the carry out of bit 7
// [RQ10] subtraction adds the two's complement, so carry and nibble carry mean no borrow
// [RQ11] rotate through carry loads carry with the bit shifted out of the source
// [RQ12] the flag register is an ordinary operand, readable and writable
// [RQ13] pointer adjust side effects leave every flag untouched
// [RQ14] flags register on the core clock when an instruction completes; unaffected flags hold
//
// The address map and the APB slave port were decided locally.
`default_nettype none
module alu_condition_flags
    import alu_flags_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic opValid,
    input wire aluop_e opCode,
    input wire logic [DATA_W-1:0] accumIn,
    input wire logic [DATA_W-1:0] fileIn,
    input wire logic [2:0] bitSel,
    input wire logic destIsFlags,
    output logic resultValid_q,
    output logic [DATA_W-1:0] resultData_q,
    output logic resultWrite_q,
    output logic [DATA_W-1:0] flagsOut_q
);
    flag_calc_if fc();

    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_d;
    logic [1:0] ctrl_q;
    logic [FLAG_W-1:0] lastAffect_q;
    logic [COUNT_W-1:0] opCount_q;
    logic apbAccess;
    logic apbWrite;
    logic apbRead;
    logic hitFlags;
    logic hitResult;
    logic hitCtrl;
    logic hitCount;
    logic mapped;
    logic flagsUpd;
    logic [DATA_W-1:0] readData;

    // merge: bits named by mask take new, others keep old
    function automatic logic [FLAG_W-1:0] mergeFlags(
        input logic [FLAG_W-1:0] oldF,
        input logic [FLAG_W-1:0] newF,
        input logic [FLAG_W-1:0] mask
    );
        mergeFlags = (oldF & ~mask) | (newF & mask);
    endfunction

    // upper bits of the flag byte are not implemented
    function automatic logic [DATA_W-1:0] flagByte(input logic [FLAG_W-1:0] f);
        flagByte = {3'b000, f}; // [RQ4]
    endfunction

    // flag register read as an operand when it is the destination
    assign fc.op = opCode;
    assign fc.opA = accumIn;
    assign fc.opB = destIsFlags ? flagByte(flags_q) : fileIn; // [RQ12]
    assign fc.carryIn = flags_q[CARRY_BIT];
    assign fc.bitSel = bitSel;

    alu_flag_calc calc (
        .fc(fc)
    );

    assign apbAccess = psel && penable && pready;
    assign apbWrite = apbAccess && pwrite;
    assign apbRead = psel && penable && !pready && !pwrite;
    assign hitFlags = (paddr == OFF_FLAGS);
    assign hitResult = (paddr == OFF_RESULT);
    assign hitCtrl = (paddr == OFF_CTRL);
    assign hitCount = (paddr == OFF_COUNT);
    assign mapped = hitFlags || hitResult || hitCtrl || hitCount;
    assign flagsUpd = ctrl_q[CTRL_UPD_BIT];

    always_comb begin
        readData = '0;
        if (hitFlags) begin
            readData = flagByte(flags_q); // [RQ4]
        end else if (hitResult) begin
            readData = resultData_q;
        end else if (hitCtrl) begin
            readData = {6'h00, ctrl_q};
        end
    end

    // next flags: software write first, then an instruction overrides
    always_comb begin
        flags_d = flags_q;
        if (apbWrite && hitFlags) begin
            flags_d = pwdata[FLAG_W-1:0]; // [RQ12]
        end
        if (opValid && flagsUpd) begin
            if (destIsFlags && fc.affect != MASK_NONE) begin
                // computed byte is dropped; flags follow the operation
                flags_d = mergeFlags(flags_q, fc.flagsNew, fc.affect); // [RQ1]
            end else if (destIsFlags) begin
                // bit ops, swap and moves store their byte into the flags
                flags_d = fc.result[FLAG_W-1:0]; // [RQ3]
            end else begin
                // unaffected flags hold their old value
                flags_d = mergeFlags(flags_q, fc.flagsNew, fc.affect); // [RQ14]
            end
        end
    end

    // reset value of the flags is undefined in the part; zero chosen here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= flags_d; // [RQ14]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flagsOut_q <= '0;
        end else begin
            flagsOut_q <= flagByte(flags_d); // [RQ4]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (apbWrite && hitCtrl) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // instruction answer: one cycle after opValid
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resultValid_q <= 1'b0;
            resultData_q <= '0;
            resultWrite_q <= 1'b0;
        end else begin
            resultValid_q <= opValid;
            if (opValid) begin
                resultData_q <= fc.result;
                // flag destination absorbs the byte, so the file is not written
                resultWrite_q <= !destIsFlags; // [RQ1]
            end else begin
                resultWrite_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lastAffect_q <= MASK_NONE;
            opCount_q <= '0;
        end else if (apbWrite && hitCount) begin
            opCount_q <= '0;
        end else if (opValid && flagsUpd) begin
            lastAffect_q <= fc.affect;
            // counter wraps; software samples it by difference
            opCount_q <= opCount_q + 16'h0001;
        end
    end

    // apb: one wait state, read data latched with pready
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= !mapped;
                if (apbRead && hitCount) begin
                    prdata <= {{(32-COUNT_W){1'b0}}, opCount_q};
                end else if (apbRead && hitResult) begin
                    prdata <= {19'h00000, lastAffect_q, readData};
                end else if (apbRead) begin
                    prdata <= {24'h000000, readData};
                end else begin
                    prdata <= '0;
                end
            end else begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/alu_flags_monitor.sv
`default_nettype none
module alu_flags_monitor
    import alu_flags_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic opValid,
    input wire aluop_e opCode,
    input wire logic [DATA_W-1:0] accumIn,
    input wire logic [DATA_W-1:0] fileIn,
    input wire logic destIsFlags,
    input wire logic resultValid_q,
    input wire logic [DATA_W-1:0] resultData_q,
    input wire logic resultWrite_q,
    input wire logic [DATA_W-1:0] flagsOut_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [8:0] sum9;
    logic [7:0] diff8;
    logic addOp, c9, ovf, srcMsb, subNeg, andZero;
    // plain add only: the carry-in form would need the old carry here
    // flag checks assume updates stay enabled while these ops run
    assign sum9 = {1'b0, fileIn} + {1'b0, accumIn};
    assign c9 = sum9[8];
    assign ovf = (fileIn[7] == accumIn[7]) && (sum9[7] != fileIn[7]);
    assign srcMsb = fileIn[7];
    assign diff8 = fileIn - accumIn;
    assign subNeg = diff8[7];
    assign andZero = ((fileIn & accumIn) == 8'h00);
    assign addOp = opValid && !destIsFlags && opCode == OP_ADD;
    bits_hi_zero_a: assert property (flagsOut_q[7:5] == 3'h0)
        else $error("upper flag bits set");
    result_timing_a: assert property (resultValid_q == $past(opValid))
        else $error("result pulse late");
    dest_nowrite_a: assert property (opValid && destIsFlags |=> !resultWrite_q)
        else $error("result written");
    flags_hold_a: assert property (!opValid && !(psel && penable && pready)
        |=> $stable(flagsOut_q)) else $error("flags moved");
    add_carry_a: assert property (addOp |=> flagsOut_q[CARRY_BIT] == $past(c9))
        else $error("carry wrong");
    add_ovf_a: assert property (addOp |=> flagsOut_q[OVF_BIT] == $past(ovf))
        else $error("overflow wrong");
    neg_flag_a: assert property (opValid && !destIsFlags && opCode == OP_SUB
        |=> flagsOut_q[NEG_BIT] == $past(subNeg)) else $error("negative wrong");
    zero_flag_a: assert property (opValid && !destIsFlags && opCode == OP_AND
        |=> flagsOut_q[ZERO_BIT] == $past(andZero)) else $error("zero wrong");
    rot_carry_a: assert property (opValid && !destIsFlags && opCode == OP_RLC
        |=> flagsOut_q[CARRY_BIT] == $past(srcMsb)) else $error("rotate carry wrong");
    bus_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer timing");
    cover property (addOp);
    cover property (opValid && destIsFlags);
    cover property (psel && penable && pready);
endmodule
bind alu_condition_flags alu_flags_monitor i_mon (.core_clk, .rst, .psel, .penable,
    .pready, .opValid, .opCode, .accumIn, .fileIn, .destIsFlags, .resultValid_q,
    .resultData_q, .resultWrite_q, .flagsOut_q);
`default_nettype wire

//--- test/exec_unit_model.sv
`default_nettype none
module exec_unit_model
    import alu_flags_pkg::*;
(
    input wire logic core_clk,
    output logic opValid,
    output aluop_e opCode,
    output logic [DATA_W-1:0] accumIn,
    output logic [DATA_W-1:0] fileIn,
    output logic [2:0] bitSel,
    output logic destIsFlags
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        opValid = 1'b0;
        opCode = OP_MOVF;
        accumIn = 8'h00;
        fileIn = 8'h00;
        bitSel = 3'h0;
        destIsFlags = 1'b0;
    end
    // bit number rides on the accum lane; accum and file lanes are driven inverted once the op is taken
    task automatic issue(input aluop_e c, input logic [7:0] a, f, input logic d);
        @(posedge core_clk);
        opValid <= 1'b1;
        opCode <= c;
        accumIn <= a;
        fileIn <= f;
        bitSel <= a[2:0];
        destIsFlags <= d;
        @(posedge core_clk);
        opValid <= 1'b0;
        accumIn <= ~a;
        fileIn <= ~f;
    endtask
endmodule
`default_nettype wire

//--- test/test_alu_condition_flags.sv
`default_nettype none
module test_alu_condition_flags
    import alu_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, slvErr, opValid, destIsFlags, resultValid_q, resultWrite_q;
    aluop_e opCode;
    logic [DATA_W-1:0] accumIn, fileIn, resultData_q, flagsOut_q;
    logic [2:0] bitSel;
    int err_total = 0, checks_done = 0, cycles = 0;
    alu_condition_flags i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .opValid, .opCode, .accumIn, .fileIn, .bitSel,
        .destIsFlags, .resultValid_q, .resultData_q, .resultWrite_q, .flagsOut_q);
    exec_unit_model i_exec (.core_clk, .opValid, .opCode, .accumIn, .fileIn, .bitSel,
        .destIsFlags);
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // a hung handshake still reaches the verdict
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n < 20, 1'b1);
    endtask
    task automatic op(input aluop_e c, input logic [7:0] a, f, input logic d,
        input logic [7:0] r, input logic [4:0] fl);
        i_exec.issue(c, a, f, d);
        #1;
        chk(resultValid_q, 1'b1);
        chk(resultWrite_q, !d);
        if (!d) begin
            chk(resultData_q, r);
        end
        chk(flagsOut_q, {3'h0, fl});
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, {27'h0, FLAGS_RESET});
        chk(slvErr, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[0], slvErr}, 2'h1);
        $display("test reset done");
        op(OP_ADD, 8'h01, 8'hFF, 1'b0, 8'h00, 5'h07);
        op(OP_ADD, 8'h7F, 8'h01, 1'b0, 8'h80, 5'h1A);
        op(OP_ADD, 8'h01, 8'h0F, 1'b0, 8'h10, 5'h02);
        op(OP_SUB, 8'h03, 8'h05, 1'b0, 8'h02, 5'h03);
        op(OP_SUB, 8'h05, 8'h03, 1'b0, 8'hFE, 5'h10);
        $display("test arith done");
        apb(1'b1, OFF_FLAGS, 32'hFFFFFF1B);
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk(rd, 32'h1B);
        op(OP_CLR, 8'h00, 8'h55, 1'b1, 8'h00, 5'h1F);
        op(OP_ADD, 8'h01, 8'hFF, 1'b1, 8'h00, 5'h02);
        $display("test dest done");
        apb(1'b1, OFF_FLAGS, 32'h0);
        op(OP_RLC, 8'h00, 8'h81, 1'b0, 8'h02, 5'h01);
        op(OP_RRC, 8'h00, 8'h01, 1'b0, 8'h80, 5'h11);
        i_exec.issue(OP_PTR, 8'h00, 8'h00, 1'b0);
        #1;
        chk(flagsOut_q, 8'h11);
        op(OP_BSET, 8'h03, 8'h00, 1'b1, 8'h00, 5'h19);
        op(OP_AND, 8'h0F, 8'hF0, 1'b0, 8'h00, 5'h0D);
        $display("test misc done");
        apb(1'b0, OFF_RESULT, 32'h0);
        chk(rd, {19'h0, MASK_ZN, 8'h00});
        op(OP_ADDC, 8'h01, 8'hFE, 1'b0, 8'h00, 5'h07);
        op(OP_SUBLIT, 8'h10, 8'h08, 1'b0, 8'hF8, 5'h12);
        op(OP_INC, 8'h00, 8'h7F, 1'b0, 8'h80, 5'h1A);
        op(OP_DEC, 8'h00, 8'h01, 1'b0, 8'h00, 5'h07);
        op(OP_XOR, 8'hF0, 8'h0F, 1'b0, 8'hFF, 5'h13);
        op(OP_OR, 8'h00, 8'h00, 1'b0, 8'h00, 5'h07);
        op(OP_SWAP, 8'h00, 8'h00, 1'b1, 8'h00, 5'h10);
        op(OP_BCLR, 8'h04, 8'h00, 1'b1, 8'h00, 5'h00);
        op(OP_ACCUM_TO_FILE_MOVE_INSTR, 8'h0B, 8'h00, 1'b1, 8'h00, 5'h0B);
        op(OP_FILE_TO_FILE_MOVE_INSTR, 8'h00, 8'h5A, 1'b0, 8'h5A, 5'h0B);
        $display("test ops done");
        // flag updates off: result still flows, flags hold
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        op(OP_XOR, 8'h0F, 8'hF0, 1'b0, 8'hFF, 5'h0B);
        apb(1'b1, OFF_CTRL, {30'h0, CTRL_RESET});
        apb(1'b1, OFF_COUNT, 32'h0);
        op(OP_MOVF, 8'h00, 8'h00, 1'b0, 8'h00, 5'h0F);
        apb(1'b0, OFF_COUNT, 32'h0);
        chk(rd, 32'h1);
        $display("test ctrl done");
        final_report();
    end
endmodule
`default_nettype wire
